// *** rtl/fhdr_pkg.sv ***
// constants and types for the floppy host data, input and configuration registers
// assumes a byte-wide host bus with a 3-bit offset inside the controller window
`default_nettype none
package fhdr_pkg;

  // host bus shape
  localparam int unsigned FHDR_ADDR_W = 3;
  localparam int unsigned FHDR_DATA_W = 8;

  // register offsets
  localparam logic [2:0] FHDR_OFF_DATA_PORT = 3'h5;
  localparam logic [2:0] FHDR_OFF_INPUT_CFG = 3'h7;

  // data port buffer
  localparam int unsigned FHDR_FIFO_DEPTH = 16;
  localparam int unsigned FHDR_PTR_W = 4;
  localparam int unsigned FHDR_CNT_W = 5;
  localparam logic [4:0] FHDR_CAP_FULL = 5'h10;
  localparam logic [4:0] FHDR_CAP_SINGLE = 5'h01;

  // field positions
  localparam int unsigned FHDR_BIT_MEDIA_CHG = 7;
  localparam int unsigned FHDR_BIT_RATE_LO = 0;
  localparam int unsigned FHDR_BIT_RATE_HI = 1;
  localparam int unsigned FHDR_BIT_NOPREC = 2;
  localparam int unsigned FHDR_BIT_DMA_GATE = 3;

  // fixed fill patterns and bus enables
  localparam logic [3:0] FHDR_DENS_FILL = 4'hF;
  localparam logic [2:0] FHDR_GATE_FILL = 3'h0;
  localparam logic [7:0] FHDR_OE_BIT7 = 8'h80;
  localparam logic [7:0] FHDR_OE_ALL = 8'hFF;
  localparam logic [7:0] FHDR_FILL_BYTE = 8'h00;

  // reset values
  localparam logic [1:0] FHDR_RATE_RST = 2'h2;
  localparam logic FHDR_NOPREC_RST = 1'b0;

  // service delay figures for the host side
  localparam int unsigned FHDR_BITS_PER_BYTE = 8;
  localparam int unsigned FHDR_SERVICE_MARGIN_NS = 1500;

  typedef enum logic [1:0] {
    FHDR_MODE_BIT7,
    FHDR_MODE_DENS,
    FHDR_MODE_GATE
  } fhdr_mode_t;

endpackage
`default_nettype wire

// *** rtl/fhdr_fifo_if.sv ***
// carrier between the register front end and the data port buffer
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface fhdr_fifo_if;
  import fhdr_pkg::*;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic [7:0] pop_data;
  logic flush;
  logic [4:0] count;

  modport ctrl (output push, output push_data, output pop, output flush, input pop_data, input count);
  modport buf_end (input push, input push_data, input pop, input flush, output pop_data, output count);
endinterface
`default_nettype wire

// *** rtl/fhdr_fifo.sv ***
// sixteen byte data port buffer with flush
// assumes the controller never pushes when full nor pops when empty
`timescale 1ns/100ps
`default_nettype none
module fhdr_fifo (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // buffer port
  fhdr_fifo_if.buf_end fifo
);
  import fhdr_pkg::*;

  logic [7:0] mem_q [FHDR_FIFO_DEPTH];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] count_q;

  assign fifo.pop_data = mem_q[rd_ptr_q];
  assign fifo.count = count_q;

  always_ff @(posedge sys_clk) begin
    if (fifo.push) begin
      mem_q[wr_ptr_q] <= fifo.push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else if (fifo.flush) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else begin
      if (fifo.push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (fifo.pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      case ({fifo.push, fifo.pop})
        2'b10: count_q <= count_q + 5'h01;
        2'b01: count_q <= count_q - 5'h01;
        default: count_q <= count_q;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/fhdr_top.sv ***
// host data port, drive input register and rate configuration register
// assumes single-cycle bus strobes on sys_clk and a controller core on the same clock
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] byte data port at offset 5
// [R2] host moves bytes only per ready/direction
// [R3] buffer disabled after any reset
// [R4] buffer disabled at command start
// [R5] buffer flushed entering execution phase
// [R6] overrun or underrun terminates command
// [R7] underrun write fills zeros then CRC
// [R8] host drains bytes after read overrun
// [R9] host services buffer within threshold delay
// [R10] input register read-only at offset 7
// [R11] first mode drives only bit 7
// [R12] bit 7 inverted media pin plus force
// [R13] second mode bit 0 dense-media low
// [R14] second mode rate bits, bits 3-6 one
// [R15] rate kept on soft, 250K on hard
// [R16] third mode bit 3 DMA gate, 4-6 zero
// [R17] third mode bit 2 noprec, rate bits
// [R18] config register write-only at offset 7
// [R19] config bits 0-1 select data rate
// [R20] reserved config bits ignored, read zero
// [R21] noprec writable, no effect, kept on soft
// [R22] latest rate write from either register wins
// [R23] ready flag gates data port access
// [R24] direction flag one means host reads
// [R25] static input selects interface mode
module fhdr_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic soft_rst,
  // host register bus
  input wire logic [fhdr_pkg::FHDR_ADDR_W-1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [fhdr_pkg::FHDR_DATA_W-1:0] bus_wdata,
  output logic [fhdr_pkg::FHDR_DATA_W-1:0] bus_rdata,
  output logic [fhdr_pkg::FHDR_DATA_W-1:0] bus_rdata_oe,
  output logic bus_rvalid,
  // status flags toward the main status register
  output logic host_xfer_ready,
  output logic xfer_direction,
  output logic dma_req,
  // static configuration
  input wire fhdr_pkg::fhdr_mode_t iface_mode,
  // neighbouring register state
  input wire logic dma_gate,
  input wire logic force_media_chg,
  input wire logic rate_sel_wr,
  input wire logic [1:0] rate_sel_wdata,
  output logic [1:0] data_rate,
  output logic noprec,
  // drive cable
  input wire logic media_changed_pin,
  // configure command
  input wire logic cfg_load,
  input wire logic cfg_fifo_on,
  input wire logic [3:0] cfg_thresh,
  // command sequencing from the core
  input wire logic cmd_start,
  input wire logic exec_start,
  input wire logic exec_end,
  input wire logic core_to_host,
  // core byte exchange
  input wire logic core_push,
  input wire logic [fhdr_pkg::FHDR_DATA_W-1:0] core_push_data,
  output logic core_push_ready,
  input wire logic core_pop,
  output logic [fhdr_pkg::FHDR_DATA_W-1:0] core_pop_data,
  output logic core_pop_valid,
  input wire logic sector_end,
  // transfer fault reporting
  output logic xfer_abort,
  output logic xfer_fault,
  output logic zero_fill
);
  import fhdr_pkg::*;

  fhdr_fifo_if fifo_bus ();

  fhdr_fifo u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .fifo(fifo_bus.buf_end)
  );

  logic chg_meta_q;
  logic chg_sync_q;
  logic [1:0] rate_q;
  logic noprec_q;
  logic fifo_cfg_q;
  logic [3:0] thresh_q;
  logic fifo_act_q;
  logic exec_q;
  logic halt_q;
  logic zero_fill_q;
  logic abort_q;
  logic fault_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_oe_q;
  logic rvalid_q;
  logic [4:0] cap;
  logic [4:0] thr_eff;
  logic [4:0] space;
  logic buf_full;
  logic buf_empty;
  logic sel_data;
  logic sel_cfg;
  logic host_push;
  logic host_pop;
  logic core_push_ok;
  logic core_pop_ok;
  logic overrun;
  logic underrun;
  logic cfg_wr;
  logic xfer_err;
  logic media_bit;
  logic [7:0] input_byte;
  logic [7:0] input_oe;

  // media change pin resynchronised before use
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chg_meta_q <= 1'b0;
      chg_sync_q <= 1'b0;
    end else begin
      chg_meta_q <= media_changed_pin;
      chg_sync_q <= chg_meta_q;
    end
  end

  assign sel_data = (bus_addr == FHDR_OFF_DATA_PORT); // [R1]
  assign sel_cfg = (bus_addr == FHDR_OFF_INPUT_CFG);
  // offset 7 writes always reach the config register; reads there never touch it
  assign cfg_wr = bus_wr && sel_cfg; // [R18]

  // effective capacity: one byte unless the configured buffer is active
  assign cap = fifo_act_q ? FHDR_CAP_FULL : FHDR_CAP_SINGLE;
  assign thr_eff = fifo_act_q ? ({1'b0, thresh_q} + 5'h01) : FHDR_CAP_SINGLE;
  assign space = cap - fifo_bus.count;
  assign buf_full = (fifo_bus.count >= cap);
  assign buf_empty = (fifo_bus.count == 5'h00);

  // host side flags
  assign xfer_direction = core_to_host; // [R24]
  assign host_xfer_ready = core_to_host ? !buf_empty : (!buf_full && !halt_q); // [R23]
  assign dma_req = exec_q && (core_to_host ? (fifo_bus.count >= thr_eff) : (!halt_q && space >= thr_eff));

  // host accesses honoured only while the ready flag allows them
  // a halted buffer still drains toward the host so the result phase can follow
  assign host_push = bus_wr && sel_data && !core_to_host && !buf_full && !halt_q; // [R23]
  assign host_pop = bus_rd && sel_data && core_to_host && !buf_empty; // [R23] [R8]

  // core side exchange
  assign core_push_ok = core_push && core_to_host && !buf_full && !halt_q;
  assign core_pop_ok = core_pop && !core_to_host && !buf_empty && !zero_fill_q && !halt_q;
  assign core_push_ready = core_to_host && !buf_full && !halt_q;
  assign core_pop_valid = zero_fill_q || (!core_to_host && !buf_empty && !halt_q);
  assign core_pop_data = zero_fill_q ? FHDR_FILL_BYTE : fifo_bus.pop_data; // [R7]

  // disk timing cannot wait: a byte with no room or no data is a fault
  assign overrun = exec_q && !halt_q && core_to_host && core_push && buf_full; // [R6]
  assign underrun = exec_q && !halt_q && !core_to_host && core_pop && buf_empty; // [R6]
  // either fault ends the transfer the same way
  assign xfer_err = overrun || underrun; // [R6]

  // direction lets only one side push in any cycle

  assign fifo_bus.push = host_push || core_push_ok;
  assign fifo_bus.push_data = host_push ? bus_wdata : core_push_data;
  assign fifo_bus.pop = host_pop || core_pop_ok;
  assign fifo_bus.flush = soft_rst || cmd_start || exec_start; // [R5]

  // data rate: hard reset forces 250K, soft reset leaves it, latest writer wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rate_q <= FHDR_RATE_RST; // [R15]
    end else if (cfg_wr) begin
      rate_q <= bus_wdata[FHDR_BIT_RATE_HI:FHDR_BIT_RATE_LO]; // [R18] [R19] [R22]
    end else if (rate_sel_wr) begin
      rate_q <= rate_sel_wdata; // [R22]
    end
  end

  // no-precompensation bit is only stored in the third mode and drives only the noprec output and input register bit 2
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      noprec_q <= FHDR_NOPREC_RST;
    end else if (cfg_wr && iface_mode == FHDR_MODE_GATE) begin
      noprec_q <= bus_wdata[FHDR_BIT_NOPREC]; // [R21] [R20]
    end
  end

  assign data_rate = rate_q;
  assign noprec = noprec_q;

  // configure command setting; any reset returns to single-byte operation
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fifo_cfg_q <= 1'b0; // [R3]
      thresh_q <= 4'h0;
    end else if (soft_rst) begin
      fifo_cfg_q <= 1'b0; // [R3]
      thresh_q <= 4'h0;
    end else if (cfg_load) begin
      fifo_cfg_q <= cfg_fifo_on;
      thresh_q <= cfg_thresh;
    end
  end

  // buffer action: off through the command phase, on from execution if configured
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fifo_act_q <= 1'b0; // [R3]
    end else if (soft_rst || cmd_start) begin
      fifo_act_q <= 1'b0; // [R3] [R4]
    end else if (exec_start) begin
      fifo_act_q <= fifo_cfg_q;
    end else if (exec_end) begin
      fifo_act_q <= 1'b0;
    end
  end

  // execution phase tracking
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      exec_q <= 1'b0;
    end else if (soft_rst || cmd_start || exec_end) begin
      exec_q <= 1'b0;
    end else if (exec_start) begin
      exec_q <= 1'b1;
    end
  end

  // a fault halts transfer until the next command or reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      halt_q <= 1'b0;
    end else if (xfer_err) begin
      halt_q <= 1'b1; // [R6]
    end else if (soft_rst || cmd_start) begin
      halt_q <= 1'b0;
    end
  end

  // underrun on a write pads the sector with zeros until the core closes it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      zero_fill_q <= 1'b0;
    end else if (underrun) begin
      zero_fill_q <= 1'b1; // [R7]
    end else if (sector_end || soft_rst) begin
      zero_fill_q <= 1'b0;
    end
  end

  // one-cycle termination request to the core
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= xfer_err; // [R6]
    end
  end

  // sticky fault flag; a new fault beats the clear at command start
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fault_q <= 1'b0;
    end else if (xfer_err) begin
      fault_q <= 1'b1;
    end else if (cmd_start || soft_rst) begin
      fault_q <= 1'b0;
    end
  end

  assign xfer_abort = abort_q;
  assign xfer_fault = fault_q;
  assign zero_fill = zero_fill_q;

  // input register layout per interface mode
  assign media_bit = !chg_sync_q || force_media_chg; // [R12]

  always_comb begin
    input_byte = 8'h00;
    input_oe = FHDR_OE_ALL;
    input_byte[FHDR_BIT_MEDIA_CHG] = media_bit;
    case (iface_mode) // [R25]
      FHDR_MODE_DENS: begin
        input_byte[6:3] = FHDR_DENS_FILL; // [R14]
        input_byte[2] = rate_q[FHDR_BIT_RATE_HI]; // [R14]
        input_byte[1] = rate_q[FHDR_BIT_RATE_LO]; // [R14]
        input_byte[0] = rate_q[1] ^ rate_q[0]; // [R13]
      end
      FHDR_MODE_GATE: begin
        input_byte[6:4] = FHDR_GATE_FILL; // [R16]
        input_byte[FHDR_BIT_DMA_GATE] = dma_gate; // [R16]
        input_byte[FHDR_BIT_NOPREC] = noprec_q; // [R17]
        input_byte[1:0] = rate_q; // [R17]
      end
      default: begin
        input_oe = FHDR_OE_BIT7; // [R11]
      end
    endcase
  end

  // read data registered one cycle after the strobe
  // a refused data port read still answers, with a zero byte
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
      rdata_oe_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (bus_rd && sel_cfg) begin
      rdata_q <= input_byte & input_oe; // [R10]
      rdata_oe_q <= input_oe; // [R11]
      rvalid_q <= 1'b1;
    end else if (bus_rd && sel_data) begin
      rdata_q <= host_pop ? fifo_bus.pop_data : 8'h00; // [R1]
      rdata_oe_q <= FHDR_OE_ALL;
      rvalid_q <= 1'b1;
    end else begin
      rdata_q <= 8'h00;
      rdata_oe_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_rdata_oe = rdata_oe_q;
  assign bus_rvalid = rvalid_q;

endmodule
`default_nettype wire

// *** sim/fhdr_top_sva.sv ***
// checker on the host register ports of fhdr_top
// assumes one clock domain and binding onto every fhdr_top instance
`timescale 1ns/100ps
`default_nettype none
module fhdr_top_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic soft_rst,
  // host bus
  input wire logic [fhdr_pkg::FHDR_ADDR_W-1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [fhdr_pkg::FHDR_DATA_W-1:0] bus_wdata,
  input wire logic [fhdr_pkg::FHDR_DATA_W-1:0] bus_rdata,
  input wire logic [fhdr_pkg::FHDR_DATA_W-1:0] bus_rdata_oe,
  input wire logic bus_rvalid,
  // register state
  input wire fhdr_pkg::fhdr_mode_t iface_mode,
  input wire logic dma_gate,
  input wire logic rate_sel_wr,
  input wire logic [1:0] rate_sel_wdata,
  input wire logic [1:0] data_rate,
  input wire logic noprec,
  // transfer
  input wire logic core_to_host,
  input wire logic xfer_direction,
  input wire logic zero_fill,
  input wire logic [fhdr_pkg::FHDR_DATA_W-1:0] core_pop_data
);
  import fhdr_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic rd7;
  logic cw;
  logic [1:0] w_rate;
  logic w_noprec;
  assign rd7 = bus_rd && bus_addr == 3'h7;
  assign cw = bus_wr && bus_addr == 3'h7;
  assign w_rate = bus_wdata[1:0];
  assign w_noprec = bus_wdata[2];
  AST_RVALID: assert property (bus_rd && (bus_addr == 3'h5 || rd7) |=> bus_rvalid)
    else $error("read got no answer");
  AST_IDLE: assert property (!bus_rd |=> !bus_rvalid && bus_rdata_oe == 8'h00)
    else $error("bus driven without a read");
  AST_AT_OE: assert property (rd7 && iface_mode == FHDR_MODE_BIT7 |=> bus_rdata_oe == 8'h80)
    else $error("first mode drives more than bit 7");
  AST_DENS: assert property (rd7 && iface_mode == FHDR_MODE_DENS
    |=> bus_rdata[6:0] == {4'hF, $past(data_rate), ^$past(data_rate)}) else $error("second mode layout wrong");
  AST_GATE: assert property (rd7 && iface_mode == FHDR_MODE_GATE
    |=> bus_rdata[6:0] == {3'h0, $past(dma_gate), $past(noprec), $past(data_rate)}) else $error("third mode layout wrong");
  AST_CFG_RATE: assert property (cw |=> data_rate == $past(w_rate))
    else $error("config write did not set rate");
  AST_RSEL: assert property (rate_sel_wr && !cw |=> data_rate == $past(rate_sel_wdata))
    else $error("rate select write lost");
  AST_SOFT: assert property (soft_rst && !cw && !rate_sel_wr |=> $stable(data_rate) && $stable(noprec))
    else $error("soft reset disturbed rate or noprec");
  AST_RSVD: assert property (cw && iface_mode != FHDR_MODE_GATE |=> $stable(noprec))
    else $error("reserved config bit stored");
  AST_NOPREC: assert property (cw && iface_mode == FHDR_MODE_GATE |=> noprec == $past(w_noprec))
    else $error("noprec not stored");
  AST_DIR: assert property (xfer_direction == core_to_host)
    else $error("direction flag wrong");
  AST_FILL: assert property (zero_fill |-> core_pop_data == 8'h00)
    else $error("fill byte not zero");
  COV_DENS: cover property (rd7 && iface_mode == FHDR_MODE_DENS);
  COV_GATEW: cover property (cw && iface_mode == FHDR_MODE_GATE);
  COV_FILL: cover property (zero_fill);
endmodule
bind fhdr_top fhdr_top_sva u_sva (.sys_clk(sys_clk), .nrst(nrst), .soft_rst(soft_rst), .bus_addr(bus_addr),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe),
  .bus_rvalid(bus_rvalid), .iface_mode(iface_mode), .dma_gate(dma_gate), .rate_sel_wr(rate_sel_wr),
  .rate_sel_wdata(rate_sel_wdata), .data_rate(data_rate), .noprec(noprec), .core_to_host(core_to_host),
  .xfer_direction(xfer_direction), .zero_fill(zero_fill), .core_pop_data(core_pop_data));
`default_nettype wire

// *** sim/fhdr_host_model.sv ***
// host processor model on the register bus
// assumes single-cycle strobes launched at the falling edge of sys_clk
`timescale 1ns/100ps
`default_nettype none
module fhdr_host_model (
  // clock
  input wire logic sys_clk,
  // bus toward the device
  output logic [2:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] bus_rdata_oe,
  input wire logic bus_rvalid,
  // status flags
  input wire logic host_xfer_ready,
  input wire logic xfer_direction
);
  initial begin
    bus_addr = 3'h0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // data port moves wait for ready and the matching direction
  // the wait is capped at 16 cycles, far inside the shortest buffer service delay
  task automatic gate(input logic [2:0] a, input logic dir);
    for (int i = 0; i < 16 && a == 3'h5 && !(host_xfer_ready && xfer_direction == dir); i++) begin
      @(negedge sys_clk);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    gate(a, 1'b0);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
    // released data no longer shows the written byte
    bus_wdata = ~v;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] oe);
    @(negedge sys_clk);
    gate(a, 1'b1);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    d = bus_rvalid ? bus_rdata : 8'hEE;
    oe = bus_rdata_oe;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the host data, input and configuration registers
// assumes fhdr_top with its checker bound and the host model on the bus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fhdr_pkg::*;
  logic sys_clk, nrst, soft_rst, bus_rd, bus_wr, bus_rvalid, host_xfer_ready, xfer_direction, dma_req;
  logic dma_gate, force_media_chg, rate_sel_wr, noprec, media_changed_pin, cfg_load, cfg_fifo_on;
  logic cmd_start, exec_start, exec_end, core_to_host, core_push, core_push_ready, core_pop, core_pop_valid;
  logic sector_end, xfer_abort, xfer_fault, zero_fill;
  logic [1:0] rate_sel_wdata, data_rate;
  logic [2:0] bus_addr;
  logic [3:0] cfg_thresh;
  logic [7:0] bus_wdata, bus_rdata, bus_rdata_oe, core_push_data, core_pop_data, d, oe;
  fhdr_mode_t iface_mode;
  int bad_count, tests_run, cyc;
  fhdr_top dut (.sys_clk, .nrst, .soft_rst, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .bus_rdata_oe,
    .bus_rvalid, .host_xfer_ready, .xfer_direction, .dma_req, .iface_mode, .dma_gate, .force_media_chg,
    .rate_sel_wr, .rate_sel_wdata, .data_rate, .noprec, .media_changed_pin, .cfg_load, .cfg_fifo_on, .cfg_thresh,
    .cmd_start, .exec_start, .exec_end, .core_to_host, .core_push, .core_push_data, .core_push_ready, .core_pop,
    .core_pop_data, .core_pop_valid, .sector_end, .xfer_abort, .xfer_fault, .zero_fill);
  fhdr_host_model h (.sys_clk, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .bus_rdata_oe, .bus_rvalid,
    .host_xfer_ready, .xfer_direction);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rd7(input string n, input logic [7:0] e);
    h.rd(3'h7, d, oe);
    chk(n, d, e);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    {nrst, soft_rst, dma_gate, force_media_chg, rate_sel_wr, cfg_load, cfg_fifo_on} = 7'h00;
    {cmd_start, exec_start, exec_end, core_push, core_pop, sector_end} = 6'h00;
    {media_changed_pin, core_to_host} = 2'h3;
    rate_sel_wdata = 2'h0;
    cfg_thresh = 4'h3;
    core_push_data = 8'hA5;
    iface_mode = FHDR_MODE_DENS;
    nx(4);
    nrst = 1'b1;
    nx(3);
    rd7("mode two after reset", 8'h7D);
    for (int r = 0; r < 4; r++) begin
      h.wr(3'h7, 8'hFC | 8'(r));
      rd7("mode two rate", {1'b0, 4'hF, 2'(r), ^2'(r)});
    end
    iface_mode = FHDR_MODE_GATE;
    dma_gate = 1'b1;
    rd7("mode three layout", 8'h0B);
    h.wr(3'h7, 8'hFC);
    rd7("mode three noprec", 8'h0C);
    nx(1);
    rate_sel_wr = 1'b1;
    rate_sel_wdata = 2'h1;
    nx(1);
    rate_sel_wr = 1'b0;
    soft_rst = 1'b1;
    nx(1);
    soft_rst = 1'b0;
    rd7("soft reset keeps", 8'h0D);
    iface_mode = FHDR_MODE_BIT7;
    media_changed_pin = 1'b0;
    nx(3);
    h.rd(3'h7, d, oe);
    chk("first mode enable", oe, 8'h80);
    chk("media bit", {7'h00, d[7]}, 8'h01);
    media_changed_pin = 1'b1;
    force_media_chg = 1'b1;
    nx(3);
    h.rd(3'h7, d, oe);
    chk("forced media bit", {7'h00, d[7]}, 8'h01);
    force_media_chg = 1'b0;
    nrst = 1'b0;
    iface_mode = FHDR_MODE_GATE;
    nx(2);
    nrst = 1'b1;
    nx(3);
    rd7("hard reset", 8'h0A);
    chk("ready empty", {7'h00, host_xfer_ready}, 8'h00);
    core_push = 1'b1;
    nx(1);
    core_push = 1'b0;
    chk("ready to host", {6'h00, host_xfer_ready, xfer_direction}, 8'h03);
    chk("single byte", {7'h00, core_push_ready}, 8'h00);
    h.rd(3'h5, d, oe);
    chk("data port read", d, 8'hA5);
    core_to_host = 1'b0;
    nx(1);
    chk("ready from host", {6'h00, host_xfer_ready, xfer_direction}, 8'h02);
    h.wr(3'h5, 8'h3C);
    chk("data port write", core_pop_valid ? core_pop_data : 8'hEE, 8'h3C);
    chk("full at one", {7'h00, host_xfer_ready}, 8'h00);
    cmd_start = 1'b1;
    nx(1);
    cmd_start = 1'b0;
    chk("start flush", {7'h00, core_pop_valid}, 8'h00);
    h.wr(3'h5, 8'h5A);
    cfg_load = 1'b1;
    cfg_fifo_on = 1'b1;
    nx(1);
    cfg_load = 1'b0;
    exec_start = 1'b1;
    nx(1);
    exec_start = 1'b0;
    chk("exec flush", {7'h00, core_pop_valid}, 8'h00);
    chk("dma from host", {7'h00, dma_req}, 8'h01);
    core_pop = 1'b1;
    nx(1);
    core_pop = 1'b0;
    chk("underrun", {4'h0, xfer_abort, xfer_fault, zero_fill, host_xfer_ready}, 8'h0E);
    chk("fill byte", core_pop_data, 8'h00);
    sector_end = 1'b1;
    nx(1);
    sector_end = 1'b0;
    chk("fill ends", {7'h00, zero_fill}, 8'h00);
    cmd_start = 1'b1;
    core_to_host = 1'b1;
    nx(1);
    cmd_start = 1'b0;
    exec_start = 1'b1;
    nx(1);
    exec_start = 1'b0;
    core_push = 1'b1;
    for (int i = 0; i < 17; i++) begin
      core_push_data = 8'(i);
      nx(1);
      if (i == 2 || i == 3) begin
        chk("dma at threshold", {7'h00, dma_req}, 8'(i >= cfg_thresh));
      end
    end
    core_push = 1'b0;
    chk("overrun", {5'h00, xfer_abort, xfer_fault, core_push_ready}, 8'h06);
    for (int i = 0; i < 16; i++) begin
      h.rd(3'h5, d, oe);
      chk("drain byte", d, 8'(i));
    end
    chk("drained", {7'h00, host_xfer_ready}, 8'h00);
    soft_rst = 1'b1;
    core_to_host = 1'b0;
    nx(1);
    soft_rst = 1'b0;
    exec_start = 1'b1;
    nx(1);
    exec_start = 1'b0;
    h.wr(3'h5, 8'h66);
    chk("soft reset single byte", {7'h00, host_xfer_ready}, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
